// ### hw/sdf_deframer.v
// Purpose: recover left/right sample words from serial clock, frame sync
//          and serial data in i2s, left- or right-justified framing
// Assumes: serial pins are asynchronous to clk_sys_in and far slower
//          (serial clock period well above four system clocks)
// Notes:   words leave msb-aligned in 24 bits with a channel flag
`default_nettype none
`include "sdf_deframer_defs.vh"

// Overview of operation
// RULE1: accepts i2s, left- or right-justified framing, 16/18/20/24-bit words
// RULE2: right-justified: sync high is left channel, low is right channel
// RULE3: data and sync sampled on serial clock rising edge only
// RULE4: right-justified msb delay is 16, 14, 12 or 8 periods by length
// RULE5: right-justified has 64 periods per frame; lsb ends each half
// RULE6: i2s is the reset default; sync low is left, high is right
// RULE7: left-justified: sync high is left; msb right at the transition
// RULE8: i2s msb comes one period after the transition; msb first always
module sdf_deframer #(
  parameter DATA_W = 24
) (
  input  wire              clk_sys_in,
  input  wire              rst_n_in,
  input  wire [1:0]        fmt_sel_in,
  input  wire [1:0]        word_len_in,
  input  wire              ser_clk_in,
  input  wire              ser_sync_in,
  input  wire              ser_data_in,
  output wire [DATA_W-1:0] smp_data_out,
  output wire              smp_right_out,
  output wire              smp_valid_out,
  input  wire              smp_ready_in,
  output reg               overrun_out
);

  // deframer states, one-hot
  localparam ST_IDLE  = 3'b001;
  localparam ST_DELAY = 3'b010;
  localparam ST_SHIFT = 3'b100;

  // two-flop synchronisers for the three serial pins
  reg [1:0] clk_sync;
  reg [1:0] sync_sync;
  reg [1:0] data_sync;
  reg       clk_prev;

  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clk_sync  <= 2'h0;
      sync_sync <= 2'h0;
      data_sync <= 2'h0;
      clk_prev  <= 1'b0;
    end else begin
      clk_sync  <= {clk_sync[0], ser_clk_in};
      sync_sync <= {sync_sync[0], ser_sync_in};
      data_sync <= {data_sync[0], ser_data_in};
      clk_prev  <= clk_sync[1];
    end
  end

  // rising edge of the serial clock; sync and data pass the same flops,
  // so they are seen with the value they held at that edge
  wire sclk_rise = clk_sync[1] & ~clk_prev; // RULE3
  wire sync_now  = sync_sync[1];
  wire data_now  = data_sync[1];

  // configuration is taken per word so a mid-word change cannot tear it
  reg [2:0]        state;
  reg [2:0]        next_state;
  reg              sync_last;
  reg [5:0]        dly_cnt;
  reg [4:0]        bit_cnt;
  reg [4:0]        word_bits;
  reg [DATA_W-1:0] shreg;
  reg              chan_right;
  reg [DATA_W:0]   word_hold;
  reg              word_valid;

  wire sync_edge = sclk_rise & (sync_now != sync_last);

  // word length decode
  reg [4:0] len_bits;
  reg [5:0] rj_dly;
  always @* begin
    case (word_len_in) // RULE1
      `SDF_WL_16: begin
        len_bits = `SDF_BITS_16;
        rj_dly   = `SDF_RJ_DLY_16; // RULE4
      end
      `SDF_WL_18: begin
        len_bits = `SDF_BITS_18;
        rj_dly   = `SDF_RJ_DLY_18; // RULE4
      end
      `SDF_WL_20: begin
        len_bits = `SDF_BITS_20;
        rj_dly   = `SDF_RJ_DLY_20; // RULE4
      end
      default: begin
        len_bits = `SDF_BITS_24;
        rj_dly   = `SDF_RJ_DLY_24; // RULE4
      end
    endcase
  end

  // msb delay counted in serial clock periods after the sync change
  reg [5:0] msb_dly;
  reg       right_of_sync;
  always @* begin
    case (fmt_sel_in)
      `SDF_FMT_LJ: begin
        msb_dly       = `SDF_LJ_DLY; // RULE7
        right_of_sync = ~sync_now;   // RULE7
      end
      `SDF_FMT_RJ: begin
        // rj delay plus word fills the 32-slot half frame
        msb_dly       = rj_dly;      // RULE5
        right_of_sync = ~sync_now;   // RULE2
      end
      default: begin
        // unused code 3 falls back to i2s like the reset default
        msb_dly       = `SDF_I2S_DLY; // RULE6 RULE8
        right_of_sync = sync_now;     // RULE6
      end
    endcase
  end

  // state transitions
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (sync_edge && msb_dly != 6'h00) begin
          next_state = ST_DELAY;
        end else if (sync_edge) begin
          next_state = ST_SHIFT;
        end
      end
      ST_DELAY: begin
        if (sync_edge && msb_dly == 6'h00) begin
          // zero-delay framing picked up mid-delay; msb already taken,
          // so staying here would count down forever
          next_state = ST_SHIFT;
        end else if (sync_edge) begin
          next_state = ST_DELAY;
        end else if (sclk_rise && dly_cnt == 6'h01) begin
          next_state = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (sync_edge && msb_dly != 6'h00) begin
          next_state = ST_DELAY;
        end else if (sync_edge) begin
          next_state = ST_SHIFT;
        end else if (sclk_rise && bit_cnt == word_bits) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // a sync change always restarts the word; in lj it is the msb slot,
  // otherwise it starts the delay count
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state      <= ST_IDLE;
      sync_last  <= 1'b0;
      dly_cnt    <= 6'h00;
      bit_cnt    <= 5'h00;
      word_bits  <= `SDF_BITS_24;
      shreg      <= {DATA_W{1'b0}};
      chan_right <= 1'b0;
    end else begin
      state <= next_state;
      if (sclk_rise) begin
        sync_last <= sync_now; // RULE3
      end
      if (sync_edge) begin
        chan_right <= right_of_sync;
        word_bits  <= len_bits;
        dly_cnt    <= msb_dly;
        if (msb_dly == 6'h00) begin
          // msb sits in the transition slot itself
          shreg   <= {{(DATA_W-1){1'b0}}, data_now}; // RULE7
          bit_cnt <= 5'h01;
        end else begin
          shreg   <= {DATA_W{1'b0}};
          bit_cnt <= 5'h00;
        end
      end else if (sclk_rise && state == ST_DELAY) begin
        dly_cnt <= dly_cnt - 6'h01;
        if (dly_cnt == 6'h01) begin
          shreg   <= {{(DATA_W-1){1'b0}}, data_now}; // RULE8
          bit_cnt <= 5'h01;
        end
      end else if (sclk_rise && state == ST_SHIFT &&
                   bit_cnt != word_bits) begin
        shreg   <= {shreg[DATA_W-2:0], data_now}; // RULE8
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end

  // word completes when the count reaches the length; msb-align it
  wire word_done = (state != ST_IDLE) && !sync_edge &&
                   (bit_cnt == word_bits) && (bit_cnt != 5'h00) &&
                   (state == ST_SHIFT || state == ST_DELAY);
  reg  word_done_q;
  wire word_fire = word_done & ~word_done_q;
  wire [4:0] pad = DATA_W[4:0] - word_bits;
  wire [DATA_W-1:0] aligned = shreg << pad;

  wire buf_ready;

  // hold the word until the buffer takes it; a stall across the whole
  // next word is flagged rather than silently overwritten
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      word_done_q <= 1'b0;
      word_hold   <= {(DATA_W+1){1'b0}};
      word_valid  <= 1'b0;
      overrun_out <= 1'b0;
    end else begin
      word_done_q <= word_done;
      if (word_fire) begin
        word_hold   <= {chan_right, aligned}; // RULE1
        word_valid  <= 1'b1;
        overrun_out <= word_valid & ~buf_ready;
      end else begin
        overrun_out <= 1'b0;
        if (buf_ready) begin
          word_valid <= 1'b0;
        end
      end
    end
  end

  wire [DATA_W:0] buf_out;

  sdf_skid_buf #(
    .WIDTH (DATA_W + 1)
  ) u_buf (
    .clk_sys_in    (clk_sys_in),
    .rst_n_in      (rst_n_in),
    .in_data_in    (word_hold),
    .in_valid_in   (word_valid),
    .in_ready_out  (buf_ready),
    .out_data_out  (buf_out),
    .out_valid_out (smp_valid_out),
    .out_ready_in  (smp_ready_in)
  );

  assign smp_data_out  = buf_out[DATA_W-1:0];
  assign smp_right_out = buf_out[DATA_W];

endmodule // sdf_deframer

`default_nettype wire

// ### hw/sdf_deframer_defs.vh
// Purpose: constants for the serial audio input deframer
// Assumes: included by bare name from hw/ design files
// Notes:   format and word-length codes are the values on the mode inputs
`ifndef SDF_DEFRAMER_DEFS_VH
`define SDF_DEFRAMER_DEFS_VH

// framing format codes
`define SDF_FMT_I2S        2'h0
`define SDF_FMT_LJ         2'h1
`define SDF_FMT_RJ         2'h2

// word length codes
`define SDF_WL_16          2'h0
`define SDF_WL_18          2'h1
`define SDF_WL_20          2'h2
`define SDF_WL_24          2'h3

// word lengths in bits
`define SDF_BITS_16        5'h10
`define SDF_BITS_18        5'h12
`define SDF_BITS_20        5'h14
`define SDF_BITS_24        5'h18

// right-justified msb delays in serial clock periods
`define SDF_RJ_DLY_16      6'h10
`define SDF_RJ_DLY_18      6'h0E
`define SDF_RJ_DLY_20      6'h0C
`define SDF_RJ_DLY_24      6'h08

// msb delay for i2s and left-justified framing
`define SDF_I2S_DLY        6'h01
`define SDF_LJ_DLY         6'h00

// serial clock periods per half frame in right-justified framing
`define SDF_RJ_HALF_SLOTS  6'h20

`endif

// ### hw/sdf_skid_buf.v
// Purpose: two-entry valid/ready buffer for recovered sample words
// Assumes: single clock, asynchronous active-low reset
// Notes:   in_ready_out is high while fewer than two entries are held
`default_nettype none

module sdf_skid_buf #(
  parameter WIDTH = 25
) (
  input  wire             clk_sys_in,
  input  wire             rst_n_in,
  input  wire [WIDTH-1:0] in_data_in,
  input  wire             in_valid_in,
  output wire             in_ready_out,
  output wire [WIDTH-1:0] out_data_out,
  output wire             out_valid_out,
  input  wire             out_ready_in
);

  reg [WIDTH-1:0] slot0;
  reg [WIDTH-1:0] slot1;
  reg [1:0]       count;

  wire push;
  wire pop;

  assign in_ready_out  = (count != 2'h2);
  assign out_valid_out = (count != 2'h0);
  assign out_data_out  = slot0;
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  // slot0 is the head; slot1 holds the second word while the sink stalls
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      slot0 <= {WIDTH{1'b0}};
      slot1 <= {WIDTH{1'b0}};
      count <= 2'h0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (count == 2'h0) begin
            slot0 <= in_data_in;
          end else begin
            slot1 <= in_data_in;
          end
          count <= count + 2'h1;
        end
        2'b01: begin
          slot0 <= slot1;
          count <= count - 2'h1;
        end
        2'b11: begin
          // push only when not full, so count is 1 here
          slot0 <= in_data_in;
        end
        default: begin
          count <= count;
        end
      endcase
    end
  end

endmodule // sdf_skid_buf

`default_nettype wire

// ### testbench/sdf_deframer_bench.sv
// Purpose: self-checking bench for the serial audio deframer
// Assumes: source model frames, sink ready driven on falling edge
// Notes:   words taken at the sink are queued and compared in order
`default_nettype none
module sdf_deframer_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        smp_ready_in = 1'b1;
  logic [1:0]  fmt_sel_in = 2'h0;
  logic [1:0]  word_len_in = 2'h0;
  wire logic   ser_clk, ser_sync, ser_data, smp_right, smp_valid, overrun;
  wire logic [23:0] smp_data;
  int          failures = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  int          overruns = 0;
  logic [24:0] got[$];
  always #5 clk_sys_in = ~clk_sys_in;
  sdf_src_model src_u (.ser_clk_out(ser_clk), .ser_sync_out(ser_sync),
                       .ser_data_out(ser_data));
  sdf_deframer dut_u (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .fmt_sel_in(fmt_sel_in), .word_len_in(word_len_in),
    .ser_clk_in(ser_clk), .ser_sync_in(ser_sync), .ser_data_in(ser_data),
    .smp_data_out(smp_data), .smp_right_out(smp_right),
    .smp_valid_out(smp_valid), .smp_ready_in(smp_ready_in),
    .overrun_out(overrun));
  // sink side: log every accepted word, count cycles and overrun pulses
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (overrun) overruns <= overruns + 1;
    if (smp_valid && smp_ready_in) got.push_back({smp_right, smp_data});
  end
  task automatic tally_and_finish();
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic expect_word(input logic [23:0] w, input logic r);
    logic [24:0] seen;
    seen = 'x;
    if (got.size() > 0) seen = got.pop_front();
    cmp_count++;
    if (seen !== {r, w}) begin
      failures++;
      $display("unexpected word: expected %h seen %h", {r, w}, seen);
    end
  endtask
  // one frame; words trimmed to length, expected msb-aligned
  task automatic run_frame(input logic [1:0] f, input logic [1:0] wl,
                           input logic [23:0] lw, input logic [23:0] rw);
    int sh;
    logic [23:0] l;
    logic [23:0] r;
    sh = (wl == 2'h3) ? 0 : 8 - 2 * wl;
    l = lw & (24'hFFFFFF >> sh);
    r = rw & (24'hFFFFFF >> sh);
    @(negedge clk_sys_in);
    fmt_sel_in = f;
    word_len_in = wl;
    src_u.send_frame(f, wl, l, r);
    if (smp_ready_in) repeat (20) @(negedge clk_sys_in);
    if (smp_ready_in) expect_word(l << sh, 1'b0);
    if (smp_ready_in) expect_word(r << sh, 1'b1);
  endtask
  // every length in i2s, code 3 taken as i2s
  task automatic t_i2s();
    for (int wl = 0; wl < 4; wl++)
      run_frame(2'h0, wl[1:0], 24'hC35A69, 24'h3CA596);
    run_frame(2'h3, 2'h3, 24'h800001, 24'h7FFFFE);
  endtask
  // every length with msb right at the transition
  task automatic t_lj();
    for (int wl = 0; wl < 4; wl++)
      run_frame(2'h1, wl[1:0], 24'hA5F00F, 24'h5A0FF1);
  endtask
  // every length with lsb in the last slot of each half
  task automatic t_rj();
    for (int wl = 0; wl < 4; wl++)
      run_frame(2'h2, wl[1:0], 24'h96C3A5, 24'h693C5B);
  endtask
  // sink stalls a whole frame; both words must wait in the buffer
  task automatic t_stall();
    @(negedge clk_sys_in);
    smp_ready_in = 1'b0;
    run_frame(2'h2, 2'h3, 24'h123456, 24'hABCDEF);
    repeat (20) @(negedge clk_sys_in);
    cmp_count++;
    if (smp_valid !== 1'b1) begin
      failures++;
      $display("unexpected valid: expected 1 seen %b", smp_valid);
    end
    smp_ready_in = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    expect_word(24'h123456, 1'b0);
    expect_word(24'hABCDEF, 1'b1);
  endtask
  // two frames against a stalled sink: the fourth word replaces the
  // held third one, so exactly one overrun pulse must show
  task automatic t_overrun();
    int base;
    base = overruns;
    cmp_count++;
    if (base !== 0) begin
      failures++;
      $display("unexpected overrun count: expected 0 seen %0d", base);
    end
    @(negedge clk_sys_in);
    smp_ready_in = 1'b0;
    run_frame(2'h1, 2'h0, 24'h00BEEF, 24'h00CAFE);
    run_frame(2'h1, 2'h0, 24'h001234, 24'h005678);
    repeat (20) @(negedge clk_sys_in);
    cmp_count++;
    if (overruns - base !== 1) begin
      failures++;
      $display("unexpected overrun count: expected 1 seen %0d",
               overruns - base);
    end
    smp_ready_in = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    expect_word(24'hBEEF00, 1'b0);
    expect_word(24'hCAFE00, 1'b1);
    expect_word(24'h567800, 1'b1);
  endtask
  // hang guard: about twice the expected run
  initial begin
    wait (cycles == 30000);
    failures++;
    tally_and_finish();
  end
  initial begin
    repeat (20) @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    repeat (5) @(negedge clk_sys_in);
    t_i2s();
    t_lj();
    t_rj();
    t_stall();
    t_overrun();
    tally_and_finish();
  end
endmodule // sdf_deframer_bench
`default_nettype wire

// ### testbench/sdf_deframer_chk.sv
// Purpose: port assertions for the serial audio deframer
// Assumes: serial pins change far from system clock edges
// Notes:   counts serial rises per sync half on the raw pins
`default_nettype none
`include "sdf_deframer_defs.vh"
module sdf_deframer_chk #(
  parameter DATA_W = 24
) (
  input wire logic              clk_sys_in,
  input wire logic              rst_n_in,
  input wire logic [1:0]        fmt_sel_in,
  input wire logic [1:0]        word_len_in,
  input wire logic              ser_clk_in,
  input wire logic              ser_sync_in,
  input wire logic              ser_data_in,
  input wire logic [DATA_W-1:0] smp_data_out,
  input wire logic              smp_right_out,
  input wire logic              smp_valid_out,
  input wire logic              smp_ready_in,
  input wire logic              overrun_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk_q;
  logic       sync_q;
  logic [5:0] rises;
  logic [3:0] idle;
  logic [5:0] nbits;
  logic       rj;
  logic       lj;
  // word length in bits and format flags
  assign nbits = (word_len_in == `SDF_WL_16) ? 6'h10 :
                 (word_len_in == `SDF_WL_18) ? 6'h12 :
                 (word_len_in == `SDF_WL_20) ? 6'h14 : 6'h18;
  assign rj = (fmt_sel_in == `SDF_FMT_RJ);
  assign lj = (fmt_sel_in == `SDF_FMT_LJ);
  // rises since sync change; idle saturates so it cannot wrap
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clk_q <= 1'b0;
      sync_q <= 1'b0;
      rises <= 6'h00;
      idle <= 4'hF;
    end else begin
      clk_q <= ser_clk_in;
      idle <= (ser_clk_in && !clk_q) ? 4'h0 :
              (idle == 4'hF) ? idle : idle + 4'h1;
      if (ser_clk_in && !clk_q) begin
        sync_q <= ser_sync_in;
        rises <= (ser_sync_in != sync_q) ? 6'h01 : rises + 6'h01;
      end
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  property p_hold;
    smp_valid_out && !smp_ready_in |=> smp_valid_out;
  endproperty
  a_hold: assert property (p_hold)
    else $error("valid dropped while stalled");
  property p_steady;
    smp_valid_out && !smp_ready_in |=>
      $stable(smp_data_out) && $stable(smp_right_out);
  endproperty
  a_steady: assert property (p_steady)
    else $error("word changed while stalled");
  property p_pad;
    smp_valid_out |-> (smp_data_out << nbits) == {DATA_W{1'b0}};
  endproperty
  a_pad: assert property (p_pad)
    else $error("pad bits not zero");
  property p_late;
    $rose(smp_valid_out) |-> idle < 4'hC;
  endproperty
  a_late: assert property (p_late)
    else $error("word not tied to a serial rise");
  property p_rj;
    $rose(smp_valid_out) && rj |-> rises == 6'h20;
  endproperty
  a_rj: assert property (p_rj)
    else $error("right-justified lsb not in last slot");
  property p_lj;
    $rose(smp_valid_out) && lj |-> rises == nbits;
  endproperty
  a_lj: assert property (p_lj)
    else $error("left-justified word ends in wrong slot");
  property p_i2s;
    $rose(smp_valid_out) && !rj && !lj |-> rises == nbits + 6'h01;
  endproperty
  a_i2s: assert property (p_i2s)
    else $error("i2s word ends in wrong slot");
  property p_chan;
    $rose(smp_valid_out) |-> smp_right_out == ((rj || lj) ^ sync_q);
  endproperty
  a_chan: assert property (p_chan)
    else $error("channel flag wrong");
  c_rj: cover property ($rose(smp_valid_out) && rj);
  c_right: cover property ($rose(smp_valid_out) && smp_right_out);
  c_stall: cover property ((smp_valid_out && !smp_ready_in) [*3]);
  c_overrun: cover property (overrun_out);
endmodule // sdf_deframer_chk
bind sdf_deframer sdf_deframer_chk #(.DATA_W(DATA_W)) chk_u (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
  .fmt_sel_in(fmt_sel_in), .word_len_in(word_len_in),
  .ser_clk_in(ser_clk_in), .ser_sync_in(ser_sync_in),
  .ser_data_in(ser_data_in), .smp_data_out(smp_data_out),
  .smp_right_out(smp_right_out), .smp_valid_out(smp_valid_out),
  .smp_ready_in(smp_ready_in), .overrun_out(overrun_out));
`default_nettype wire

// ### testbench/sdf_src_model.sv
// Purpose: serial audio source driving clock, sync and data
// Assumes: 125 ns serial period, clock stands low between frames
// Notes:   idle slots toggle data so stale bits cannot pass
`default_nettype none
module sdf_src_model (
  output logic ser_clk_out,
  output logic ser_sync_out,
  output logic ser_data_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // pins idle low before the first frame
  initial begin
    ser_clk_out = 1'b0;
    ser_sync_out = 1'b0;
    ser_data_out = 1'b0;
  end
  // one period; pins move only while the clock is low
  task automatic slot(input logic s, input logic d);
    ser_sync_out = s;
    ser_data_out = d;
    #62.5 ser_clk_out = 1'b1;
    #62.5 ser_clk_out = 1'b0;
  endtask
  // one slot on the right level, then left and right halves
  task automatic send_frame(input logic [1:0] fmt, input logic [1:0] wl,
                            input logic [23:0] lw, input logic [23:0] rw);
    int n;
    int d;
    int k;
    logic lft;
    logic [23:0] w;
    n = 16 + 2 * wl + ((wl == 2'h3) ? 2 : 0);
    d = (fmt == 2'h2) ? 32 - n : (fmt == 2'h1) ? 0 : 1;
    lft = (fmt == 2'h1) || (fmt == 2'h2);
    #1.3;
    slot(!lft, !ser_data_out);
    for (int s = 0; s < 64; s++) begin
      w = (s < 32) ? lw : rw;
      k = (s % 32) - d;
      slot((s < 32) ? lft : !lft,
           (k >= 0 && k < n) ? w[n - 1 - k] : !ser_data_out);
    end
    ser_data_out = !ser_data_out;
  endtask
endmodule // sdf_src_model
`default_nettype wire
